// File: rtl/alert_clamp_pkg.sv
// Package with offsets, field layouts and reset values of the alert and clamp status bank.
package alert_clamp_pkg;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] upper_channel_limit_alerts_index = 8'h16;
  localparam logic [7:0] input_protection_flags_index     = 8'h1A;
  localparam logic [7:0] device_setup_index               = 8'h20;
  localparam logic [7:0] irq_status_index                 = 8'h40;
  localparam logic [7:0] irq_mask_index                   = 8'h41;

  // Byte address is four times the printed register index.
  localparam int unsigned word_shift = 2;
  localparam int unsigned addr_width = 10;

  // ----------------------------------------------------------------
  // Reset values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] alerts_reset     = 8'h00;
  localparam logic [7:0] clamp_reset      = 8'h00;
  localparam logic [7:0] setup_reset      = 8'h10;
  localparam logic [7:0] irq_mask_reset   = 8'h00;
  localparam int unsigned alert_mode_bit  = 7;
  localparam int unsigned first_channel   = 4;
  localparam int unsigned channel_count   = 4;
  localparam int unsigned input_count     = 8;
  localparam int unsigned result_width    = 16;
  localparam int unsigned hyst_width      = 11;

  // Interrupt status bits.
  localparam int unsigned irq_alert_bit   = 0;
  localparam int unsigned irq_clamp_bit   = 1;

  // Bus slave states.
  typedef enum logic [1:0] {
    bus_idle = 2'b01,
    bus_ack  = 2'b10
  } bus_state_t;

endpackage

// File: rtl/alert_clamp_status_regs.sv
// Upper-channel alert status, clamp flags and interrupt logic behind a Wishbone slave.
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Alert register at 0x16 resets to zero; bit pairs per channel 7 down to 4.
// - Low alert sets when result is at or below the lower threshold.
// - High alert sets when result is at or above the upper threshold.
// - Alerts only set while detection is enabled for that channel.
// - Reading the alert register clears every alert bit.
// - With mode bit one, an in-band later conversion clears that channel's alerts.
// - Read-only clamp register at 0x1A resets to zero, bit x for input x.
// - A clamp bit reads one while that input's clamp is active.
// - Clamp bits are not latched and follow the live clamp state.
// - Mode select is setup bit 7 at 0x20, reset zero.
module alert_clamp_status_regs (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        clk_en,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Conversion results from the converter
  input  wire logic        result_valid,
  input  wire logic [2:0]  result_channel,
  input  wire logic [15:0] result_data,
  input  wire logic [63:0] low_limits,
  input  wire logic [63:0] high_limits,
  input  wire logic [43:0] band_widths,
  input  wire logic [3:0]  detect_enables,
  // Live clamp signals from the protection circuits
  input  wire logic [7:0]  clamp_active,
  // Setup and interrupt
  output logic             alert_mode,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Synchronisers for the analog clamp levels
  // ----------------------------------------------------------------
  logic [7:0] clamp_meta;
  logic [7:0] overvoltage_active_bits;

  always_ff @(posedge clk) begin
    if (srst) begin
      clamp_meta              <= alert_clamp_pkg::clamp_reset;
      overvoltage_active_bits <= alert_clamp_pkg::clamp_reset;
    end else if (clk_en) begin
      clamp_meta              <= clamp_active;
      overvoltage_active_bits <= clamp_meta;
    end
  end

  // ----------------------------------------------------------------
  // Channel selection and classification
  // ----------------------------------------------------------------
  conversion_if conv ();

  logic [1:0]  sel_ch;
  logic [15:0] sel_low;
  logic [15:0] sel_high;
  logic [10:0] sel_band;

  always_comb begin
    sel_ch   = result_channel[1:0];
    sel_low  = low_limits[sel_ch*16 +: 16];
    sel_high = high_limits[sel_ch*16 +: 16];
    sel_band = band_widths[sel_ch*11 +: 11];
  end

  band_check u_band_check (
    .result     (result_data),
    .low_limit  (sel_low),
    .high_limit (sel_high),
    .band_width (sel_band),
    .low_hit    (conv.low_hit),
    .high_hit   (conv.high_hit),
    .in_band    (conv.in_band)
  );

  // Only results of channels 4 to 7 belong to this bank.
  assign conv.valid     = result_valid && result_channel[2];
  assign conv.channel   = sel_ch;
  assign conv.detect_en = detect_enables[sel_ch];

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  alert_clamp_pkg::bus_state_t bus_state;
  logic       bus_req;
  logic       bus_write;
  logic [7:0] reg_index;
  logic       alert_read;

  assign bus_req   = wb_cyc_i && wb_stb_i && (bus_state == alert_clamp_pkg::bus_idle);
  assign bus_write = bus_req && wb_we_i && wb_sel_i[0];
  assign reg_index = 8'(wb_adr_i >> alert_clamp_pkg::word_shift);
  assign alert_read = bus_req && !wb_we_i &&
                      (reg_index == alert_clamp_pkg::upper_channel_limit_alerts_index);

  always_ff @(posedge clk) begin
    if (srst) begin
      bus_state <= alert_clamp_pkg::bus_idle;
      wb_ack_o  <= 1'b0;
    end else if (clk_en) begin
      case (bus_state)
        alert_clamp_pkg::bus_idle: begin
          if (bus_req) begin
            bus_state <= alert_clamp_pkg::bus_ack;
            wb_ack_o  <= 1'b1;
          end
        end
        alert_clamp_pkg::bus_ack: begin
          bus_state <= alert_clamp_pkg::bus_idle;
          wb_ack_o  <= 1'b0;
        end
        default: begin
          bus_state <= alert_clamp_pkg::bus_idle;
          wb_ack_o  <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Alert status
  // ----------------------------------------------------------------
  logic [7:0] upper_channel_limit_alerts;
  logic [7:0] next_upper_channel_limit_alerts;
  logic [7:0] alert_set;
  logic [7:0] alert_clear;
  logic [7:0] setup;

  assign alert_mode = setup[alert_clamp_pkg::alert_mode_bit];

  always_comb begin
    alert_set   = 8'h00;
    alert_clear = 8'h00;
    if (conv.valid && conv.detect_en) begin
      // Bit 2n+1 is low, bit 2n is high for channel 4+n.
      alert_set[{conv.channel, 1'b1}] = conv.low_hit;
      alert_set[{conv.channel, 1'b0}] = conv.high_hit;
    end
    if (conv.valid && alert_mode && conv.in_band) begin
      alert_clear[{conv.channel, 1'b1}] = 1'b1;
      alert_clear[{conv.channel, 1'b0}] = 1'b1;
    end
    if (alert_read) begin
      alert_clear = 8'hFF;
    end
    // A set in the same cycle as a clear wins.
    next_upper_channel_limit_alerts =
      (upper_channel_limit_alerts & ~alert_clear) | alert_set;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      upper_channel_limit_alerts <= alert_clamp_pkg::alerts_reset;
    end else if (clk_en) begin
      upper_channel_limit_alerts <= next_upper_channel_limit_alerts;
    end
  end

  // ----------------------------------------------------------------
  // Setup register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      setup <= alert_clamp_pkg::setup_reset;
    end else if (clk_en) begin
      if (bus_write && (reg_index == alert_clamp_pkg::device_setup_index)) begin
        setup <= wb_dat_i[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [1:0] irq_event;
  logic [7:0] clamp_prev;
  logic [1:0] irq_w1c;

  always_comb begin
    irq_event = 2'b00;
    irq_event[alert_clamp_pkg::irq_alert_bit] = |alert_set;
    irq_event[alert_clamp_pkg::irq_clamp_bit] = |(overvoltage_active_bits & ~clamp_prev);
    irq_w1c = 2'b00;
    if (bus_write && (reg_index == alert_clamp_pkg::irq_status_index)) begin
      irq_w1c = wb_dat_i[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      clamp_prev <= alert_clamp_pkg::clamp_reset;
      irq_status <= 2'b00;
      irq_mask   <= alert_clamp_pkg::irq_mask_reset[1:0];
      irq        <= 1'b0;
    end else if (clk_en) begin
      clamp_prev <= overvoltage_active_bits;
      // Events win over a write-one-to-clear in the same cycle.
      irq_status <= (irq_status & ~irq_w1c) | irq_event;
      if (bus_write && (reg_index == alert_clamp_pkg::irq_mask_index)) begin
        irq_mask <= wb_dat_i[1:0];
      end
      irq <= |(((irq_status & ~irq_w1c) | irq_event) & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      wb_dat_o <= 32'h00000000;
    end else if (clk_en) begin
      if (bus_req && !wb_we_i) begin
        // Unmapped addresses read as zero and are still acknowledged.
        if (reg_index == alert_clamp_pkg::upper_channel_limit_alerts_index) begin
          wb_dat_o <= {24'h000000, upper_channel_limit_alerts};
        end else if (reg_index == alert_clamp_pkg::input_protection_flags_index) begin
          wb_dat_o <= {24'h000000, overvoltage_active_bits};
        end else if (reg_index == alert_clamp_pkg::device_setup_index) begin
          wb_dat_o <= {24'h000000, setup};
        end else if (reg_index == alert_clamp_pkg::irq_status_index) begin
          wb_dat_o <= {30'h0, irq_status};
        end else if (reg_index == alert_clamp_pkg::irq_mask_index) begin
          wb_dat_o <= {30'h0, irq_mask};
        end else begin
          wb_dat_o <= 32'h00000000;
        end
      end
    end
  end

endmodule
`default_nettype wire

// File: rtl/band_check.sv
// Combinational classifier of one result against thresholds and hysteresis band.
`timescale 1ns/100ps
`default_nettype none
module band_check (
  // Conversion and thresholds
  input  wire logic [15:0] result,
  input  wire logic [15:0] low_limit,
  input  wire logic [15:0] high_limit,
  input  wire logic [10:0] band_width,
  // Classification
  output logic             low_hit,
  output logic             high_hit,
  output logic             in_band
);
  logic [16:0] low_release;
  logic [16:0] high_release;

  always_comb begin
    low_hit      = (result <= low_limit);
    high_hit     = (result >= high_limit);
    // Widened so that limit plus band cannot wrap at full scale.
    low_release  = {1'b0, low_limit} + {6'h00, band_width};
    high_release = {1'b0, high_limit} - {6'h00, band_width};
    // In band means the result has moved back inside both released limits.
    in_band = ({1'b0, result} > low_release) &&
              (({1'b0, result} < high_release) || high_release[16]) == 1'b1 &&
              !high_release[16];
  end
endmodule
`default_nettype wire

// File: rtl/conversion_if.sv
// Interface carrying one conversion result and its channel into the alert tracker.
`timescale 1ns/100ps
`default_nettype none
interface conversion_if;
  logic        valid;
  logic [1:0]  channel;
  logic        low_hit;
  logic        high_hit;
  logic        in_band;
  logic        detect_en;

  modport source (output valid, output channel, output low_hit, output high_hit,
                  output in_band, output detect_en);
  modport sink (input valid, input channel, input low_hit, input high_hit,
                input in_band, input detect_en);
endinterface
`default_nettype wire

// File: verification/alert_clamp_monitor.sv
// Checker of bus timing, reset, clamp view and alert clearing at the status bank ports.
`timescale 1ns/100ps
`default_nettype none
module alert_clamp_monitor (
  // Clock and reset
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        clk_en,
  // Bus and inputs
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        result_valid,
  input wire logic [7:0]  clamp_active,
  // Outputs
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        alert_mode,
  input wire logic        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic tk;
  logic rd_alert;
  logic rd_clamp;
  logic rd_unmapped;
  logic wr_setup;
  // Plain nets, so that properties see sampled values and never the values after the edge.
  assign tk          = wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;
  assign rd_alert    = tk && !wb_we_i && wb_adr_i == 10'h058;
  assign rd_clamp    = tk && !wb_we_i && wb_adr_i == 10'h068;
  assign rd_unmapped = tk && !wb_we_i && wb_adr_i == 10'h3FC;
  assign wr_setup    = tk && wb_we_i && wb_sel_i[0] && wb_adr_i == 10'h080;
  // Two alert reads with no conversion between them; the second must find nothing left.
  sequence alert_twice;
    rd_alert && !result_valid ##1 !result_valid [*2] ##1 rd_alert && !result_valid;
  endsequence
  sequence clamp_steady;
    $stable(clamp_active) [*5] ##0 rd_clamp;
  endsequence
  ack_timing_a: assert property (tk |=> wb_ack_o) else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  reset_quiet_a: assert property (disable iff (1'b0) srst |=> !wb_ack_o && !irq && !alert_mode)
    else $error("outputs active after reset");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  unmapped_zero_a: assert property (rd_unmapped |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  clamp_view_a: assert property (clamp_steady |=> wb_dat_o == {24'h0, $past(clamp_active)})
    else $error("clamp flags differ from clamps");
  read_clear_a: assert property (alert_twice |=> wb_dat_o == 32'h0)
    else $error("alerts survived a read");
  mode_set_a: assert property (wr_setup && wb_dat_i[7] |-> ##[1:2] alert_mode)
    else $error("mode bit not set");
  mode_clear_a: assert property (wr_setup && !wb_dat_i[7] |-> ##[1:2] !alert_mode)
    else $error("mode bit not cleared");
endmodule
bind alert_clamp_status_regs alert_clamp_monitor mon (.clk(clk), .srst(srst), .clk_en(clk_en),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .result_valid(result_valid),
  .clamp_active(clamp_active), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .alert_mode(alert_mode), .irq(irq));
`default_nettype wire

// File: verification/tb_alert_clamp_status_regs.sv
// Self-checking bench of the alert and clamp status bank.
`timescale 1ns/100ps
`default_nettype none
module tb_alert_clamp_status_regs;
  logic        clk = 0, srst = 1, clk_en = 1, cyc = 0, stb = 0, we = 0, rv = 0, ack, mode, irq;
  logic [9:0]  adr = '0;
  logic [3:0]  sel = 4'hF, den = 4'h0;
  logic [31:0] di = '0, dout;
  logic [2:0]  ch = 3'h4;
  logic [15:0] rdat = '0;
  logic [63:0] lo = '0, hi = '0;
  logic [43:0] bw = '0;
  logic [7:0]  clamp = '0;
  logic [31:0] expq[$];
  int          err_total = 0, cmp_count = 0;
  initial forever #10 clk = ~clk;
  alert_clamp_status_regs uut (.clk(clk), .srst(srst), .clk_en(clk_en), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(di),
    .wb_dat_o(dout), .wb_ack_o(ack), .result_valid(rv), .result_channel(ch),
    .result_data(rdat), .low_limits(lo), .high_limits(hi), .band_widths(bw),
    .detect_enables(den), .clamp_active(clamp), .alert_mode(mode), .irq(irq));
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic s);
    cmp(n, {31'h0, e}, {31'h0, s});
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    int k;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    di <= {24'h0, d};
    for (k = 0; k < 20 && ack !== 1'b1; k++) @(posedge clk);
    if (k == 20) begin
      err_total++;
      end_of_test();
    end
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    expq.push_back({24'h0, e});
    bus(0, a, 8'h00);
  endtask
  task automatic conv(input int c, input logic [15:0] v);
    @(posedge clk);
    rv <= 1;
    ch <= 3'(c);
    rdat <= v;
    @(posedge clk);
    rv <= 0;
  endtask
  // Read data is taken at the ack edge, before the slave's own updates land.
  always @(posedge clk)
    if (ack === 1'b1 && we === 1'b0 && expq.size() > 0) cmp("read data", expq.pop_front(), dout);
  initial begin
    logic [7:0] r;
    int n;
    void'($urandom(32'h770F));
    repeat (12) @(posedge clk);
    srst <= 0;
    rd(10'h058, 8'h00);
    rd(10'h068, 8'h00);
    rd(10'h080, 8'h10);
    rd(10'h3FC, 8'h00);
    chk_bit("alert mode", 1'b0, mode);
    $display("test reset done");
    lo <= {4{16'h1000}};
    hi <= {4{16'hF000}};
    bw <= {4{11'h100}};
    for (n = 4; n < 8; n++) conv(n, 16'h0000);
    rd(10'h058, 8'h00);
    den <= 4'hF;
    for (n = 4; n < 8; n++) begin
      conv(n, 16'h1001 + 16'($urandom_range(32'hDFFE)));
      conv(n, 16'h1000);
      conv(n, 16'hF000);
    end
    rd(10'h058, 8'hFF);
    rd(10'h058, 8'h00);
    $display("test thresholds done");
    for (n = 0; n < 2; n++) begin
      bus(1, 10'h080, n ? 8'h90 : 8'h10);
      chk_bit("alert mode", n[0], mode);
      conv(5, 16'h1000);
      conv(6, 16'hF000);
      conv(5, 16'h8000);
      conv(6, 16'h1100);
      rd(10'h058, n ? 8'h10 : 8'h18);
    end
    fork
      rd(10'h058, 8'h00);
      conv(7, 16'h0000);
    join
    rd(10'h058, 8'h80);
    $display("test clearing done");
    r = 8'($urandom_range(1, 255));
    clamp <= r;
    repeat (6) @(posedge clk);
    rd(10'h068, r);
    bus(1, 10'h068, 8'hFF);
    clamp <= 8'h00;
    repeat (6) @(posedge clk);
    rd(10'h068, 8'h00);
    $display("test clamps done");
    bus(1, 10'h100, 8'h03);
    bus(1, 10'h104, 8'h00);
    conv(4, 16'h0000);
    repeat (3) @(posedge clk);
    chk_bit("irq", 1'b0, irq);
    rd(10'h100, 8'h01);
    bus(1, 10'h104, 8'h01);
    repeat (3) @(posedge clk);
    chk_bit("irq", 1'b1, irq);
    rd(10'h058, 8'h02);
    bus(1, 10'h100, 8'h01);
    repeat (3) @(posedge clk);
    chk_bit("irq", 1'b0, irq);
    $display("test interrupt done");
    end_of_test();
  end
endmodule
`default_nettype wire
